// ===== core/rxwcs_ctrl.v
// Receiver carrier sense, wake-up sequencer and frequency readouts
//
// Summary of operation
// - Carrier detect compares averaged signal strength with a 5-bit threshold per gain setting.
// - Carrier detect asserts when strength exceeds threshold plus 8, latch mode zero.
// - Current carrier detect is readable as a status flag.
// - Status pin source 0100 drives carrier detect onto the status pin.
// - Status pin source 1101 drives the demodulator sample clock onto the pin.
// - Power-down mode 11 selects automatic power-up sequencing controls.
// - Sleep request write of 1 puts the sequencer in power-down awaiting wake.
// - Wake source 1 starts the sequence on serial select falling edge.
// - Wake source 0 uses data pin falling edge, only with split data pins.
// - After wake, receiver powers up, checks carrier, returns to sleep if none.
// - Settling wait from 3-bit field, carrier wait from 4-bit field.
// - Calibration every sequence, every 16th, every 256th, or never.
// - Average frequency offset is signed 8-bit, one unit is baud over 16.
// - Offset reading is valid for FSK and GFSK only, not on-off keying.
// - Instantaneous frequency is signed 8-bit, one unit is baud over 8.
// - Instantaneous reading updates once per sample clock, eight times baud.
// - Lowest baud rate is 1 kBaud, bounding the slowest sample clock.
// - Demodulation filter cut-off sits at 0.6 times the baud rate.
`include "rxwcs_defines.vh"

module rxwcs_ctrl #(
  parameter MAX_SAMPLE_CYC = `RXWCS_MAX_SAMPLE_CYC,
  parameter WAIT_UNIT_CYC = `RXWCS_WAIT_UNIT_CYC
) (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Signal strength from the gain loop
  input wire [7:0] rssi_avg,
  input wire rssi_valid,
  // Carrier sense configuration
  input wire [4:0] cs_threshold,
  input wire [4:0] max_gain,
  input wire detect_latch_mode,
  // Status pin
  input wire [3:0] status_pin_select,
  output reg status_pin,
  output reg carrier_sense,
  // Sequencer configuration
  input wire [1:0] powerdown_mode_select,
  input wire sequencer_sleep_request,
  input wire wake_source_select,
  input wire split_data_pins,
  input wire [2:0] rx_wait,
  input wire [3:0] cs_wait,
  input wire [1:0] calibration_interval,
  // Wake pins
  input wire serial_select_pin,
  input wire data_inout_pin,
  // Receiver and calibration control
  output reg rx_power_en,
  output reg cal_start,
  input wire cal_done,
  output reg seq_powered_down,
  output reg [2:0] seq_state,
  // Demodulator timing and frequency
  input wire [13:0] sample_period,
  input wire [7:0] inst_frequency_word_in,
  input wire fsk_mode,
  output reg demod_sample_clock,
  output reg demod_sample_tick,
  output reg [7:0] inst_frequency_word_reading,
  output reg [7:0] frequency_word_offset_reading
);

  localparam ST_IDLE = 3'h0;
  localparam ST_SLEEP = 3'h1;
  localparam ST_CAL = 3'h2;
  localparam ST_SETTLE = 3'h3;
  localparam ST_CS_WAIT = 3'h4;
  localparam ST_RX_ON = 3'h5;

  localparam [`RXWCS_TIMER_W-1:0] UNIT = WAIT_UNIT_CYC[`RXWCS_TIMER_W-1:0];
  localparam [13:0] MAX_PERIOD = MAX_SAMPLE_CYC[13:0];

  // ---------------------------------------------------------------
  // Carrier sense
  // ---------------------------------------------------------------
  reg [4:0] gain_seen;
  wire [7:0] cs_limit;
  wire cs_above;

  assign cs_limit = {3'h0, cs_threshold} + `RXWCS_CS_OFFSET;
  assign cs_above = rssi_avg > cs_limit;

  // A gain change makes the old strength meaningless, so the flag drops
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gain_seen <= 5'h00;
      carrier_sense <= 1'b0;
    end else begin
      gain_seen <= max_gain;
      if (gain_seen != max_gain) begin
        carrier_sense <= 1'b0;
      end else if (rssi_valid && !detect_latch_mode) begin
        carrier_sense <= cs_above;
      end
    end
  end

  // ---------------------------------------------------------------
  // Demodulator sample clock, eight samples per baud
  // ---------------------------------------------------------------
  reg [13:0] smp_cnt;
  reg [13:0] period_eff;

  // Clamp keeps the rate at or above the slowest legal baud
  always @* begin
    if (sample_period > MAX_PERIOD) begin
      period_eff = MAX_PERIOD;
    end else if (sample_period < `RXWCS_MIN_SAMPLE_CYC) begin
      period_eff = `RXWCS_MIN_SAMPLE_CYC;
    end else begin
      period_eff = sample_period;
    end
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      smp_cnt <= 14'h0000;
      demod_sample_tick <= 1'b0;
      demod_sample_clock <= 1'b0;
    end else begin
      if (smp_cnt >= period_eff - 14'h0001) begin
        smp_cnt <= 14'h0000;
        demod_sample_tick <= 1'b1;
      end else begin
        smp_cnt <= smp_cnt + 14'h0001;
        demod_sample_tick <= 1'b0;
      end
      demod_sample_clock <= smp_cnt < {1'b0, period_eff[13:1]};
    end
  end

  // ---------------------------------------------------------------
  // Demodulation filter and instantaneous frequency
  // ---------------------------------------------------------------
  // First-order low-pass, gain 3/8 per sample; at eight samples per
  // baud this puts the cut-off close to 0.6 baud without a multiplier
  reg signed [10:0] filt_acc;
  wire signed [10:0] filt_in;
  wire signed [11:0] filt_diff;
  wire signed [13:0] filt_diff3;
  wire signed [13:0] filt_step;
  wire signed [10:0] next_filt;

  assign filt_in = {inst_frequency_word_in, 3'h0};
  assign filt_diff = {filt_in[10], filt_in} - {filt_acc[10], filt_acc};
  assign filt_diff3 = {filt_diff[11], filt_diff, 1'b0} + {{2{filt_diff[11]}}, filt_diff};
  assign filt_step = filt_diff3 >>> `RXWCS_FILT_FRAC;
  assign next_filt = filt_acc + filt_step[10:0];

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      filt_acc <= 11'h000;
      inst_frequency_word_reading <= 8'h00;
    end else if (demod_sample_tick) begin
      filt_acc <= next_filt;
      inst_frequency_word_reading <= next_filt[10:3];
    end
  end

  // ---------------------------------------------------------------
  // Average frequency offset: eight readings summed, scaled to baud/16
  // ---------------------------------------------------------------
  reg signed [10:0] avg_sum;
  reg [2:0] avg_cnt;
  wire signed [10:0] avg_total;
  wire signed [10:0] avg_scaled;

  assign avg_total = avg_sum + {{3{inst_frequency_word_reading[7]}}, inst_frequency_word_reading};
  // Sum/8 in baud/8 units is sum/4 in baud/16 units
  assign avg_scaled = avg_total >>> (`RXWCS_AVG_LEN_LOG2 - 1);

  // Reading is left untouched outside FSK since OOK gives no usable offset
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      avg_sum <= 11'h000;
      avg_cnt <= 3'h0;
      frequency_word_offset_reading <= 8'h00;
    end else if (demod_sample_tick) begin
      if (!fsk_mode) begin
        avg_sum <= 11'h000;
        avg_cnt <= 3'h0;
      end else if (avg_cnt == 3'h7) begin
        avg_sum <= 11'h000;
        avg_cnt <= 3'h0;
        if (avg_scaled > 11'sh07f) begin
          frequency_word_offset_reading <= 8'h7f;
        end else if (avg_scaled < -11'sh080) begin
          frequency_word_offset_reading <= 8'h80;
        end else begin
          frequency_word_offset_reading <= avg_scaled[7:0];
        end
      end else begin
        avg_sum <= avg_total;
        avg_cnt <= avg_cnt + 3'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Status pin routing
  // ---------------------------------------------------------------
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_pin <= 1'b0;
    end else begin
      case (status_pin_select)
        `RXWCS_PIN_SEL_CARRIER: begin
          status_pin <= carrier_sense;
        end
        `RXWCS_PIN_SEL_DEMOD_CLK: begin
          status_pin <= demod_sample_clock;
        end
        default: begin
          status_pin <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Wake pins
  // ---------------------------------------------------------------
  // Each pin has its own synchroniser; selecting after the edge
  // detectors means a change of source never fakes an edge
  wire [1:0] pin_fall;
  wire wake_event;

  rxwcs_fall_detect #(
    .WIDTH(2)
  ) u_fall (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_raw({data_inout_pin, serial_select_pin}),
    .pin_fall(pin_fall)
  );

  assign wake_event = wake_source_select ? pin_fall[0] :
    (pin_fall[1] & split_data_pins);

  // ---------------------------------------------------------------
  // Automatic power-up sequencer
  // ---------------------------------------------------------------
  reg [2:0] next_state;
  reg [`RXWCS_TIMER_W-1:0] timer;
  reg [7:0] seq_count;
  wire seq_mode;
  reg cal_due;
  wire timer_done;
  wire [`RXWCS_TIMER_W-1:0] settle_cyc;
  wire [`RXWCS_TIMER_W-1:0] cs_cyc;

  assign seq_mode = powerdown_mode_select == `RXWCS_POWERDOWN_MODE_SELECT_SEQ;
  assign timer_done = timer == {`RXWCS_TIMER_W{1'b0}};

  // Waits are (field + 1) units so a zero field still settles briefly
  assign settle_cyc = ({9'h000, rx_wait} + 12'h001) * UNIT;
  assign cs_cyc = ({8'h00, cs_wait} + 12'h001) * UNIT;

  always @* begin
    case (calibration_interval)
      `RXWCS_CAL_EVERY: cal_due = 1'b1;
      `RXWCS_CAL_16TH: cal_due = seq_count[3:0] == 4'h0;
      `RXWCS_CAL_256TH: cal_due = seq_count == 8'h00;
      default: cal_due = 1'b0;
    endcase
  end

  always @* begin
    next_state = seq_state;
    if (!seq_mode) begin
      next_state = ST_IDLE;
    end else if (sequencer_sleep_request) begin
      next_state = ST_SLEEP;
    end else begin
      case (seq_state)
        ST_IDLE: begin
          next_state = ST_RX_ON;
        end
        ST_SLEEP: begin
          if (wake_event) begin
            next_state = cal_due ? ST_CAL : ST_SETTLE;
          end
        end
        ST_CAL: begin
          if (cal_done && !cal_start) begin
            next_state = ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (timer_done) begin
            next_state = ST_CS_WAIT;
          end
        end
        ST_CS_WAIT: begin
          if (carrier_sense) begin
            next_state = ST_RX_ON;
          end else if (timer_done) begin
            next_state = ST_SLEEP;
          end
        end
        ST_RX_ON: begin
          next_state = ST_RX_ON;
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_state <= ST_IDLE;
      timer <= {`RXWCS_TIMER_W{1'b0}};
      seq_count <= 8'h00;
      cal_start <= 1'b0;
    end else begin
      seq_state <= next_state;
      cal_start <= 1'b0;
      if (next_state == ST_SETTLE && seq_state != ST_SETTLE) begin
        timer <= settle_cyc - 12'h001;
      end else if (next_state == ST_CS_WAIT && seq_state != ST_CS_WAIT) begin
        timer <= cs_cyc - 12'h001;
      end else if (!timer_done) begin
        timer <= timer - 12'h001;
      end
      if (seq_state == ST_SLEEP && next_state != ST_SLEEP && next_state != ST_IDLE) begin
        seq_count <= seq_count + 8'h01;
      end
      if (next_state == ST_CAL && seq_state != ST_CAL) begin
        cal_start <= 1'b1;
      end
    end
  end

  // Outside sequencing mode the receiver is powered by other means
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_power_en <= 1'b0;
      seq_powered_down <= 1'b0;
    end else begin
      rx_power_en <= next_state == ST_SETTLE || next_state == ST_CS_WAIT ||
        next_state == ST_RX_ON;
      seq_powered_down <= next_state == ST_SLEEP;
    end
  end

endmodule // rxwcs_ctrl

// ===== core/rxwcs_defines.vh
// Constants for the receiver wake-up and carrier-sense control block
`ifndef RXWCS_DEFINES_VH
`define RXWCS_DEFINES_VH

// Clock
`define RXWCS_CLK_MHZ 125
`define RXWCS_CLK_HZ 125000000

// Carrier sense
`define RXWCS_CS_OFFSET 8'h08
`define RXWCS_LEVEL_W 5
`define RXWCS_RSSI_W 8

// Status pin source codes
`define RXWCS_PIN_SEL_W 4
`define RXWCS_PIN_SEL_CARRIER 4'h4
`define RXWCS_PIN_SEL_DEMOD_CLK 4'hd

// Power-down mode
`define RXWCS_POWERDOWN_MODE_SELECT_W 2
`define RXWCS_POWERDOWN_MODE_SELECT_SEQ 2'h3

// Calibration interval codes
`define RXWCS_CAL_EVERY 2'h0
`define RXWCS_CAL_16TH 2'h1
`define RXWCS_CAL_256TH 2'h2
`define RXWCS_CAL_NEVER 2'h3

// Sequencer wait granularity
`define RXWCS_WAIT_UNIT_NS 1000
`define RXWCS_WAIT_UNIT_CYC ((`RXWCS_WAIT_UNIT_NS * `RXWCS_CLK_MHZ) / 1000)
`define RXWCS_TIMER_W 12

// Demodulator sample clock
`define RXWCS_SAMPLES_PER_BAUD 8
`define RXWCS_MIN_BAUD 1000
`define RXWCS_MAX_SAMPLE_CYC (`RXWCS_CLK_HZ / (`RXWCS_SAMPLES_PER_BAUD * `RXWCS_MIN_BAUD))
`define RXWCS_PERIOD_W 14
`define RXWCS_MIN_SAMPLE_CYC 14'h0002

// Frequency readings
`define RXWCS_FREQUENCY_WORD_W 8
`define RXWCS_FILT_FRAC 3
`define RXWCS_AVG_LEN_LOG2 3

`endif

// ===== core/rxwcs_fall_detect.v
// Per-bit two-stage synchroniser with falling-edge pulse
module rxwcs_fall_detect #(
  parameter WIDTH = 2
) (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Raw pins and edge pulses
  input wire [WIDTH-1:0] pin_raw,
  output wire [WIDTH-1:0] pin_fall
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta;
      reg sync;
      reg prev;
      // Reset to the idle high level so an idle pin gives no edge after reset
      always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          meta <= 1'b1;
          sync <= 1'b1;
          prev <= 1'b1;
        end else begin
          meta <= pin_raw[i];
          sync <= meta;
          prev <= sync;
        end
      end
      assign pin_fall[i] = prev & ~sync;
    end
  endgenerate

endmodule // rxwcs_fall_detect

// ===== verification/rxwcs_ctrl_props.sv
// Concurrent checks on carrier sense, status pin and sequencer outputs
module rxwcs_ctrl_props #(
  parameter MAX_SAMPLE_CYC = 64,
  parameter WAIT_UNIT_CYC = 2
) (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Carrier sense
  input wire [7:0] rssi_avg,
  input wire rssi_valid,
  input wire [4:0] cs_threshold,
  input wire [4:0] max_gain,
  input wire detect_latch_mode,
  input wire carrier_sense,
  // Status pin
  input wire [3:0] status_pin_select,
  input wire status_pin,
  input wire demod_sample_clock,
  input wire demod_sample_tick,
  // Sequencer
  input wire [1:0] powerdown_mode_select,
  input wire sequencer_sleep_request,
  input wire rx_power_en,
  input wire cal_start,
  input wire seq_powered_down,
  input wire [2:0] seq_state
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_cs_compare: assert property (rssi_valid && !detect_latch_mode && $stable(max_gain) |=>
    carrier_sense == ({1'b0, $past(rssi_avg)} > ({4'h0, $past(cs_threshold)} + 9'h008)))
    else $error("carrier flag disagrees with threshold compare");
  chk_latch_hold: assert property (detect_latch_mode && $stable(max_gain) |=>
    $stable(carrier_sense)) else $error("carrier flag moved while frozen");
  chk_gain_clear: assert property (!$stable(max_gain) |=> !carrier_sense)
    else $error("carrier flag not cleared on gain change");
  chk_pin_carrier: assert property (status_pin_select == 4'h4 |=>
    status_pin == $past(carrier_sense)) else $error("status pin not following carrier");
  chk_pin_clock: assert property (status_pin_select == 4'hd |=>
    status_pin == $past(demod_sample_clock)) else $error("status pin not following clock");
  chk_tick_single: assert property (demod_sample_tick |=> !demod_sample_tick)
    else $error("sample tick longer than one cycle");
  chk_sleep_entry: assert property (powerdown_mode_select == 2'h3 && sequencer_sleep_request
    |=> seq_state == 3'h1 && seq_powered_down) else $error("sleep request not obeyed");
  chk_seq_off: assert property (powerdown_mode_select != 2'h3 |=> seq_state == 3'h0
    && !rx_power_en && !seq_powered_down) else $error("sequencer active outside its mode");
  chk_cal_pulse: assert property (cal_start |-> seq_state == 3'h2 ##1 !cal_start)
    else $error("calibration start outside calibration state");
  chk_rx_power: assert property (rx_power_en |-> seq_state inside {3'h3, 3'h4, 3'h5})
    else $error("receiver powered in wrong state");
  chk_sleep_flag: assert property (seq_powered_down |-> seq_state == 3'h1)
    else $error("power-down flag outside sleep");
  chk_clk_phase: assert property (demod_sample_tick |->
    !demod_sample_clock ##1 demod_sample_clock) else $error("sample clock phase wrong at tick");
endmodule // rxwcs_ctrl_props

bind rxwcs_ctrl rxwcs_ctrl_props #(.MAX_SAMPLE_CYC(MAX_SAMPLE_CYC),
  .WAIT_UNIT_CYC(WAIT_UNIT_CYC)) u_props (.ref_clk, .sys_rst, .rssi_avg, .rssi_valid,
  .cs_threshold, .max_gain, .detect_latch_mode, .carrier_sense, .status_pin_select,
  .status_pin, .demod_sample_clock, .demod_sample_tick, .powerdown_mode_select,
  .sequencer_sleep_request, .rx_power_en, .cal_start, .seq_powered_down, .seq_state);

// ===== verification/rxwcs_ctrl_tb.sv
// Self-checking testbench for the wake-up and carrier-sense control block
module rxwcs_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int UNIT = 2;
  logic ref_clk, sys_rst, rssi_valid, detect_latch_mode, sequencer_sleep_request;
  logic wake_source_select, split_data_pins, fsk_mode, wake_req, cal_slow, taken;
  logic serial_select_pin, data_inout_pin, cal_done, cal_start, rx_power_en;
  logic status_pin, carrier_sense, seq_powered_down, demod_sample_clock, demod_sample_tick;
  logic [7:0] rssi_avg, inst_frequency_word_in, inst_frequency_word_reading, frequency_word_offset_reading, off_in;
  logic [4:0] cs_threshold, max_gain;
  logic [3:0] status_pin_select, cs_wait;
  logic [2:0] rx_wait, seq_state;
  logic [1:0] powerdown_mode_select, calibration_interval;
  logic [13:0] sample_period;
  logic exp_q[$];
  int len_q[$];
  int n_fail = 0, n_tests = 0, seed, run_len = 0, per_len, n_cal = 0;
  int pers[3];
  logic [1:0] codes[4] = '{2'h2, 2'h1, 2'h0, 2'h3};
  int cal_exp[4] = '{1, 1, 16, 0};

  rxwcs_ctrl #(.MAX_SAMPLE_CYC(64), .WAIT_UNIT_CYC(UNIT)) u_dut (.ref_clk, .sys_rst,
    .rssi_avg, .rssi_valid, .cs_threshold, .max_gain, .detect_latch_mode,
    .status_pin_select, .status_pin, .carrier_sense, .powerdown_mode_select,
    .sequencer_sleep_request, .wake_source_select, .split_data_pins, .rx_wait, .cs_wait,
    .calibration_interval, .serial_select_pin, .data_inout_pin, .rx_power_en, .cal_start,
    .cal_done, .seq_powered_down, .seq_state, .sample_period, .inst_frequency_word_in, .fsk_mode,
    .demod_sample_clock, .demod_sample_tick, .inst_frequency_word_reading, .frequency_word_offset_reading);
  rxwcs_host_model u_host (.ref_clk, .wake_req, .wake_source_select, .cal_slow,
    .cal_start, .serial_select_pin, .data_inout_pin, .cal_done);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: output %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic check_num(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      n_fail++;
      $display("wrong value at %0t: count %0d, expected %0d", $time, got, exp);
    end
  endtask

  task automatic timeout;
    n_fail++;
    $display("wrong value at %0t: wait ran out", $time);
    stop_test();
  endtask

  task automatic wait_for(input logic [2:0] st, input logic want);
    int i;
    for (i = 0; i < 400 && ((seq_state === st) != want); i++) @(negedge ref_clk);
    if (i == 400) timeout();
  endtask

  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (demod_sample_tick !== 1'b1 && n < 200);
    if (n >= 200) timeout();
  endtask

  // One wake from sleep; ends back in sleep or in receive
  task automatic wake(input bit to_rx);
    @(negedge ref_clk);
    rx_wait = 3'($random(seed));
    cs_wait = 4'($random(seed));
    cal_slow = 1'($random(seed));
    if (!to_rx) len_q.push_back((rx_wait + cs_wait + 2) * UNIT);
    wake_req = 1'b1;
    repeat (2) @(negedge ref_clk);
    wake_req = 1'b0;
    wait_for(3'h1, 1'b0);
    wait_for(to_rx ? 3'h5 : 3'h1, 1'b1);
  endtask

  // Result watchers: oldest note against each result that appears
  always @(posedge ref_clk) taken <= rssi_valid && !detect_latch_mode && !sys_rst;
  always @(negedge ref_clk) begin
    if (taken && exp_q.size() > 0) check_val({7'h0, carrier_sense}, {7'h0, exp_q.pop_front()});
    if (cal_start === 1'b1) n_cal++;
    if (seq_state === 3'h3 || seq_state === 3'h4) run_len++;
    else if (run_len > 0) begin
      if (seq_state === 3'h1 && len_q.size() > 0) check_num(run_len, len_q.pop_front());
      run_len = 0;
    end
  end

  initial begin
    seed = 32330;
    {rssi_valid, detect_latch_mode, sequencer_sleep_request, wake_req, cal_slow} = '0;
    {fsk_mode, split_data_pins} = '0;
    wake_source_select = 1'b1;
    rssi_avg = 8'h00;
    cs_threshold = 5'h0a;
    max_gain = 5'h10;
    status_pin_select = 4'h4;
    powerdown_mode_select = 2'h0;
    {rx_wait, cs_wait, calibration_interval} = '0;
    sample_period = 14'h0004;
    inst_frequency_word_in = 8'h00;
    sys_rst = 1'b1;
    repeat (3) @(negedge ref_clk);
    sys_rst = 1'b0;
    // Back-to-back samples around the threshold boundary
    for (int k = 0; k < 25; k++) begin
      @(negedge ref_clk);
      cs_threshold = 5'($random(seed));
      rssi_avg = 8'((k == 24) ? cs_threshold + 9 : cs_threshold + 8 + {$random(seed)} % 3);
      rssi_valid = 1'b1;
      exp_q.push_back(rssi_avg > cs_threshold + 8'h08);
    end
    @(negedge ref_clk) detect_latch_mode = 1'b1;
    rssi_avg = 8'h00;
    repeat (4) @(negedge ref_clk);
    check_val({7'h0, carrier_sense}, 8'h01);
    {detect_latch_mode, rssi_valid} = '0;
    max_gain = max_gain + 5'h01;
    @(negedge ref_clk) check_val({7'h0, carrier_sense}, 8'h00);
    // Sample clock period at both ends of its range
    status_pin_select = 4'hd;
    pers = '{2, 64, 2 + {$random(seed)} % 63};
    foreach (pers[i]) begin
      wait_tick(per_len);
      sample_period = pers[i][13:0];
      wait_tick(per_len);
      wait_tick(per_len);
      check_num(per_len, pers[i]);
    end
    // Constant negative input settles filter and offset exactly
    sample_period = 14'h0004;
    fsk_mode = 1'b1;
    inst_frequency_word_in = 8'(8'hff - {$random(seed)} % 60);
    repeat (100) wait_tick(per_len);
    check_val(inst_frequency_word_reading, inst_frequency_word_in);
    check_val(frequency_word_offset_reading, {inst_frequency_word_in[6:0], 1'b0});
    // Outside FSK the offset reading must hold its last value
    off_in = inst_frequency_word_in;
    fsk_mode = 1'b0;
    inst_frequency_word_in = 8'h20;
    repeat (20) wait_tick(per_len);
    check_val(frequency_word_offset_reading, {off_in[6:0], 1'b0});
    // Sequencer
    powerdown_mode_select = 2'h3;
    rssi_valid = 1'b1;
    @(negedge ref_clk) sequencer_sleep_request = 1'b1;
    @(negedge ref_clk) sequencer_sleep_request = 1'b0;
    check_val({7'h0, seq_powered_down}, 8'h01);
    foreach (codes[i]) begin
      calibration_interval = codes[i];
      n_cal = 0;
      repeat (16) wake(1'b0);
      check_num(n_cal, cal_exp[i]);
    end
    wake_source_select = 1'b0;
    @(negedge ref_clk) wake_req = 1'b1;
    repeat (2) @(negedge ref_clk);
    wake_req = 1'b0;
    repeat (20) @(negedge ref_clk);
    check_val({5'h0, seq_state}, 8'h01);
    split_data_pins = 1'b1;
    wake(1'b0);
    wake_source_select = 1'b1;
    rssi_avg = 8'hff;
    wake(1'b1);
    check_val({7'h0, rx_power_en}, 8'h01);
    powerdown_mode_select = 2'h0;
    repeat (2) @(negedge ref_clk);
    check_val({5'h0, seq_state}, 8'h00);
    stop_test();
  end
endmodule // rxwcs_ctrl_tb

// ===== verification/rxwcs_host_model.sv
// Host-side model: wake pin stimulus and calibration completion
module rxwcs_host_model (
  // Clock
  input wire ref_clk,
  // Requests from the bench
  input wire wake_req,
  input wire wake_source_select,
  input wire cal_slow,
  // Device side
  input wire cal_start,
  output logic serial_select_pin,
  output logic data_inout_pin,
  output logic cal_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_cnt = 0;

  // Pins idle high; only the selected pin is pulled low
  assign serial_select_pin = !(wake_req && wake_source_select);
  assign data_inout_pin = !(wake_req && !wake_source_select);

  // Done is a single pulse, not a held level: the sequencer must catch it in calibration
  always @(posedge ref_clk) begin
    if (cal_start === 1'b1) wait_cnt <= cal_slow ? 12 : 1;
    else if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
    cal_done <= (wait_cnt == 1);
  end
endmodule // rxwcs_host_model
